// File: hdl/gpcfg_top.sv
// configuration and routing for two multi-function pins behind AHB-Lite
//
// Behaviour
// - first pin register, reset 0x0A, nvm loaded
// - second pin register, reset 0x0A
// - all fields default from nvm values
// - first pin: io, error in, sync clock, power good
// - second pin: io, error in, reference, monitor
// - codes 4-7: sleep1, sleep2, wake1, wake2
// - filter off: synchronise input only
// - filter on: 8 us stable before change
// - pull enable bit connects pull resistor
// - pull direction 0 down, 1 up
// - output type 0 push-pull, 1 open-drain
// - direction bit 0 input, 1 output
`timescale 1ns/1ps
module gpcfg_top
   import gpcfg_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        nvm_load,
   input  wire logic [7:0]  nvm_pin6_default,
   input  wire logic [7:0]  nvm_pin7_default,
   input  wire logic        pin6_in,
   output logic             pin6_out,
   output logic             pin6_oe,
   output logic             pin6_pull_up,
   output logic             pin6_pull_down,
   input  wire logic        pin7_in,
   output logic             pin7_out,
   output logic             pin7_oe,
   output logic             pin7_pull_up,
   output logic             pin7_pull_down,
   input  wire logic        sync_clock_source,
   input  wire logic        power_good_source,
   output logic             mcu_error_input,
   output logic             sleep_request_1,
   output logic             sleep_request_2,
   output logic             wake_input_1,
   output logic             wake_input_2,
   output logic             reference_voltage_output,
   output logic             voltage_monitor_input_1
);

   logic [7:0]  pin6_config;
   logic [7:0]  pin7_config;
   logic [7:0]  pin_data;
   logic        wr_pend;
   logic [31:0] wr_addr;
   logic [31:0] next_hrdata;
   logic        filt6;
   logic        filt7;
   gpcfg_func_t pin6_function_select;
   gpcfg_func_t pin7_function_select;
   logic        pin6_drive;
   logic        pin7_drive;
   logic        pin6_value;
   logic        pin7_value;
   logic        next_pin6_oe;
   logic        next_pin7_oe;
   logic        next_pin6_out;
   logic        next_pin7_out;

   // ******************************************************
   // field views
   // ******************************************************
   assign pin6_function_select = gpcfg_func_t'(pin6_config[SEL_HI:SEL_LO]);
   assign pin7_function_select = gpcfg_func_t'(pin7_config[SEL_HI:SEL_LO]);

   // ******************************************************
   // bus slave: zero wait state, always OKAY
   // ******************************************************
   wire addr_phase = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b0;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 32'h00000000;
      end else begin
         wr_pend <= addr_phase && hwrite;
         if (addr_phase) begin
            wr_addr <= haddr;
         end
      end
   end

   // unmapped addresses read as zero
   always_comb begin
      next_hrdata = 32'h00000000;
      unique case (haddr)
         PIN6_ADDR: next_hrdata = {24'h000000, pin6_config};
         PIN7_ADDR: next_hrdata = {24'h000000, pin7_config};
         DATA_ADDR: next_hrdata = {24'h000000, pin_data[7:6], filt7, filt6,
                                   pin_data[3:0]};
         default:   next_hrdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= next_hrdata;
      end
   end

   // ******************************************************
   // configuration registers; nvm load outranks a bus write
   // ******************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin6_config <= CFG_RESET;
      end else if (nvm_load) begin
         pin6_config <= nvm_pin6_default;
      end else if (wr_pend && wr_addr == PIN6_ADDR) begin
         pin6_config <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin7_config <= CFG_RESET;
      end else if (nvm_load) begin
         pin7_config <= nvm_pin7_default;
      end else if (wr_pend && wr_addr == PIN7_ADDR) begin
         pin7_config <= hwdata[7:0];
      end
   end

   // only the two output value bits are stored; input bits are live
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_data <= DATA_RESET;
      end else if (wr_pend && wr_addr == DATA_ADDR) begin
         pin_data <= {6'h00, hwdata[OUT7_BIT], hwdata[OUT6_BIT]};
      end
   end

   // ******************************************************
   // input filters, active only while the pin is not driven
   // ******************************************************
   gpcfg_filter u_filt6 (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .filter_enable  (pin6_config[FILT_BIT] && !pin6_drive),
      .pin_level      (pin6_in),
      .filtered_level (filt6)
   );

   gpcfg_filter u_filt7 (
      .hclk           (hclk),
      .hresetn        (hresetn),
      .filter_enable  (pin7_config[FILT_BIT] && !pin7_drive),
      .pin_level      (pin7_in),
      .filtered_level (filt7)
   );

   // ******************************************************
   // output drive selection
   // ******************************************************
   always_comb begin
      pin6_drive = 1'b0;
      pin6_value = 1'b0;
      unique case (pin6_function_select)
         FUNC_GPIO: begin
            pin6_drive = pin6_config[DIR_BIT];
            pin6_value = pin_data[OUT6_BIT];
         end
         FUNC_ALT2: begin
            pin6_drive = 1'b1;
            pin6_value = sync_clock_source;
         end
         FUNC_ALT3: begin
            pin6_drive = 1'b1;
            pin6_value = power_good_source;
         end
         FUNC_ERR_IN, FUNC_SLEEP1, FUNC_SLEEP2, FUNC_WAKE1, FUNC_WAKE2: begin
            pin6_drive = 1'b0;
            pin6_value = 1'b0;
         end
      endcase
   end

   // reference output and monitor input are analog roles: no digital drive
   always_comb begin
      pin7_drive = 1'b0;
      pin7_value = 1'b0;
      if (pin7_function_select == FUNC_GPIO) begin
         pin7_drive = pin7_config[DIR_BIT];
         pin7_value = pin_data[OUT7_BIT];
      end
   end

   // open drain only pulls low, so the enable follows the inverted data
   always_comb begin
      next_pin6_oe  = pin6_drive && (!pin6_config[OTYPE_BIT] || !pin6_value);
      next_pin6_out = pin6_value && !pin6_config[OTYPE_BIT];
      next_pin7_oe  = pin7_drive && (!pin7_config[OTYPE_BIT] || !pin7_value);
      next_pin7_out = pin7_value && !pin7_config[OTYPE_BIT];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin6_oe  <= 1'b0;
         pin6_out <= 1'b0;
         pin7_oe  <= 1'b0;
         pin7_out <= 1'b0;
      end else begin
         pin6_oe  <= next_pin6_oe;
         pin6_out <= next_pin6_out;
         pin7_oe  <= next_pin7_oe;
         pin7_out <= next_pin7_out;
      end
   end

   // ******************************************************
   // pull resistors
   // ******************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin6_pull_up   <= 1'b0;
         pin6_pull_down <= 1'b0;
         pin7_pull_up   <= 1'b0;
         pin7_pull_down <= 1'b0;
      end else begin
         pin6_pull_up   <= pin6_config[PULL_EN_BIT] && pin6_config[PULL_DIR_BIT];
         pin6_pull_down <= pin6_config[PULL_EN_BIT] && !pin6_config[PULL_DIR_BIT];
         pin7_pull_up   <= pin7_config[PULL_EN_BIT] && pin7_config[PULL_DIR_BIT];
         pin7_pull_down <= pin7_config[PULL_EN_BIT] && !pin7_config[PULL_DIR_BIT];
      end
   end

   // ******************************************************
   // routing of pin inputs to core functions
   // ******************************************************
   // first pin wins when both pins pick the same function
   function automatic logic route_in(
      input gpcfg_func_t sel6,
      input gpcfg_func_t sel7,
      input gpcfg_func_t code,
      input logic        lvl6,
      input logic        lvl7,
      input logic        idle
   );
      logic result;
      result = idle;
      if (sel6 == code) begin
         result = lvl6;
      end else if (sel7 == code) begin
         result = lvl7;
      end
      return result;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mcu_error_input <= ERR_IDLE;
         sleep_request_1 <= SLEEP_IDLE;
         sleep_request_2 <= SLEEP_IDLE;
         wake_input_1    <= WAKE_IDLE;
         wake_input_2    <= WAKE_IDLE;
      end else begin
         mcu_error_input <= route_in(pin6_function_select, pin7_function_select,
                                     FUNC_ERR_IN, filt6, filt7, ERR_IDLE);
         sleep_request_1 <= route_in(pin6_function_select, pin7_function_select,
                                     FUNC_SLEEP1, filt6, filt7, SLEEP_IDLE);
         sleep_request_2 <= route_in(pin6_function_select, pin7_function_select,
                                     FUNC_SLEEP2, filt6, filt7, SLEEP_IDLE);
         wake_input_1    <= route_in(pin6_function_select, pin7_function_select,
                                     FUNC_WAKE1, filt6, filt7, WAKE_IDLE);
         wake_input_2    <= route_in(pin6_function_select, pin7_function_select,
                                     FUNC_WAKE2, filt6, filt7, WAKE_IDLE);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         reference_voltage_output <= 1'b0;
         voltage_monitor_input_1  <= 1'b0;
      end else begin
         reference_voltage_output <= (pin7_function_select == FUNC_ALT2);
         voltage_monitor_input_1  <= (pin7_function_select == FUNC_ALT3);
      end
   end

endmodule // gpcfg_top

// File: hdl/gpcfg_pkg.sv
// constants and types shared by the pin configuration block
package gpcfg_pkg;

   // ******************************************************
   // register map (printed offsets are indices, word aligned)
   // ******************************************************
   localparam logic [7:0]  PIN6_IDX     = 8'h36;
   localparam logic [7:0]  PIN7_IDX     = 8'h37;
   localparam logic [7:0]  DATA_IDX     = 8'h3D;
   localparam logic [31:0] PIN6_ADDR    = {22'h000000, PIN6_IDX, 2'h0};
   localparam logic [31:0] PIN7_ADDR    = {22'h000000, PIN7_IDX, 2'h0};
   localparam logic [31:0] DATA_ADDR    = {22'h000000, DATA_IDX, 2'h0};

   // ******************************************************
   // configuration register fields and reset value
   // ******************************************************
   localparam logic [7:0]  CFG_RESET    = 8'h0A;
   localparam int          SEL_HI       = 7;
   localparam int          SEL_LO       = 5;
   localparam int          FILT_BIT     = 4;
   localparam int          PULL_EN_BIT  = 3;
   localparam int          PULL_DIR_BIT = 2;
   localparam int          OTYPE_BIT    = 1;
   localparam int          DIR_BIT      = 0;

   // ******************************************************
   // pin data register fields
   // ******************************************************
   localparam int          OUT6_BIT     = 0;
   localparam int          OUT7_BIT     = 1;
   localparam int          IN6_BIT      = 4;
   localparam int          IN7_BIT      = 5;
   localparam logic [7:0]  DATA_RESET   = 8'h00;

   // ******************************************************
   // bus encodings
   // ******************************************************
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic        HRESP_OKAY    = 1'b0;

   // ******************************************************
   // timing
   // ******************************************************
   localparam int          CLK_PERIOD_PS   = 4000;
   localparam int          DEGLITCH_US     = 8;
   localparam int          DEGLITCH_INT    =
      (DEGLITCH_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          CNT_W           = 11;
   localparam logic [CNT_W-1:0] DEGLITCH_CYCLES = CNT_W'(DEGLITCH_INT);

   // ******************************************************
   // idle levels of routed inputs when no pin selects them
   // ******************************************************
   localparam logic        ERR_IDLE     = 1'b1;
   localparam logic        SLEEP_IDLE   = 1'b1;
   localparam logic        WAKE_IDLE    = 1'b0;

   // ******************************************************
   // pin function codes
   // ******************************************************
   typedef enum logic [2:0] {
      FUNC_GPIO   = 3'h0,
      FUNC_ERR_IN = 3'h1,
      FUNC_ALT2   = 3'h2,
      FUNC_ALT3   = 3'h3,
      FUNC_SLEEP1 = 3'h4,
      FUNC_SLEEP2 = 3'h5,
      FUNC_WAKE1  = 3'h6,
      FUNC_WAKE2  = 3'h7
   } gpcfg_func_t;

endpackage

// File: hdl/gpcfg_filter.sv
// input synchroniser with optional stability filter for one pin
`timescale 1ns/1ps
module gpcfg_filter
   import gpcfg_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic filter_enable,
   input  wire logic pin_level,
   output logic      filtered_level
);

   logic             sync_a;
   logic             sync_b;
   logic [CNT_W-1:0] stable_count;

   // ******************************************************
   // two stage synchroniser
   // ******************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= pin_level;
         sync_b <= sync_a;
      end
   end

   // ******************************************************
   // level accepted only after a full stable window
   // ******************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stable_count   <= '0;
         filtered_level <= 1'b0;
      end else if (!filter_enable) begin
         stable_count   <= '0;
         filtered_level <= sync_b;
      end else if (sync_b == filtered_level) begin
         stable_count   <= '0;
      end else if (stable_count == DEGLITCH_CYCLES - 1'b1) begin
         stable_count   <= '0;
         filtered_level <= sync_b;
      end else begin
         stable_count   <= stable_count + 1'b1;
      end
   end

endmodule // gpcfg_filter

// File: sim/gpcfg_pad_model.sv
// pad model: resolves one two-way pin from device drive, far-side drive and pulls
`timescale 1ns/1ps
module gpcfg_pad_model (
   input  wire logic hclk,
   input  wire logic oe,
   input  wire logic out,
   input  wire logic pull_up,
   input  wire logic pull_down,
   input  wire logic ext_en,
   input  wire logic ext_lvl,
   output logic      pin
);
   logic last = 1'b0;
   // a floating pad shows the inverse of its last level, never a stale value
   always_comb begin
      if (oe) pin = out;
      else if (ext_en) pin = ext_lvl;
      else if (pull_up) pin = 1'b1;
      else if (pull_down) pin = 1'b0;
      else pin = ~last;
   end
   always_ff @(posedge hclk) last <= pin;
endmodule // gpcfg_pad_model

// File: sim/gpcfg_top_sva.sv
// checker for the pin configuration block ports
`timescale 1ns/1ps
module gpcfg_top_sva
   import gpcfg_pkg::*;
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       hreadyout,
   input wire logic       hresp,
   input wire logic       nvm_load,
   input wire logic [7:0] nvm_pin6_default,
   input wire logic [7:0] nvm_pin7_default,
   input wire logic       pin6_pull_up,
   input wire logic       pin6_pull_down,
   input wire logic       pin6_oe,
   input wire logic       pin7_pull_up,
   input wire logic       pin7_pull_down,
   input wire logic       pin7_oe,
   input wire logic       reference_voltage_output,
   input wire logic       voltage_monitor_input_1
);
   // ****************
   // assertions
   // ****************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == HRESP_OKAY)
      else $error("hresp not okay");
   a_ready_high: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state inserted");
   a_reset_cfg: assert property ($rose(hresetn) |=> pin6_pull_down && pin7_pull_down && !pin6_oe)
      else $error("reset config wrong");
   a_pull6_excl: assert property (!(pin6_pull_up && pin6_pull_down))
      else $error("pin6 both pulls on");
   a_pull7_excl: assert property (!(pin7_pull_up && pin7_pull_down))
      else $error("pin7 both pulls on");
   a_nvm_pull_off: assert property (nvm_load && !nvm_pin7_default[3] |-> ##2 !pin7_pull_up && !pin7_pull_down)
      else $error("pin7 pull not off after load");
   a_nvm_pull_up: assert property (nvm_load && nvm_pin6_default[3:2] == 2'h3 |-> ##2 pin6_pull_up)
      else $error("pin6 pull up missing");
   a_nvm_ref_out: assert property (nvm_load && nvm_pin7_default[7:5] == 3'h2 |-> ##2 reference_voltage_output)
      else $error("reference not selected");
   a_ref_no_drive: assert property (reference_voltage_output |-> !pin7_oe)
      else $error("pin7 driven as reference");
   a_ref_vmon_excl: assert property (!(reference_voltage_output && voltage_monitor_input_1))
      else $error("two pin7 functions at once");
   c_nvm: cover property (nvm_load);
   c_oe6: cover property ($rose(pin6_oe));
   c_ref: cover property ($rose(reference_voltage_output));
endmodule // gpcfg_top_sva

bind gpcfg_top gpcfg_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
   .hresp(hresp), .nvm_load(nvm_load), .nvm_pin6_default(nvm_pin6_default),
   .nvm_pin7_default(nvm_pin7_default), .pin6_pull_up(pin6_pull_up),
   .pin6_pull_down(pin6_pull_down), .pin6_oe(pin6_oe), .pin7_pull_up(pin7_pull_up),
   .pin7_pull_down(pin7_pull_down), .pin7_oe(pin7_oe),
   .reference_voltage_output(reference_voltage_output),
   .voltage_monitor_input_1(voltage_monitor_input_1));

// File: sim/gpio_pin_function_config_tb_top.sv
// testbench for the pin configuration block
`timescale 1ns/1ps
module gpio_pin_function_config_tb_top import gpcfg_pkg::*;;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, nvm_load = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0;
   logic [7:0]  nvm6 = 8'h00, nvm7 = 8'h00;
   logic        sync_src = 1'b0, pg_src = 1'b0, e6_en = 1'b0, e6_lvl = 1'b0;
   logic        e7_en = 1'b0, e7_lvl = 1'b0, hreadyout, hresp, idl;
   logic        p6_in, p6_out, p6_oe, p6_pu, p6_pd, p7_in, p7_out, p7_oe, p7_pu, p7_pd;
   logic        err_o, slp1, slp2, wk1, wk2, ref_o, vmon_o;
   logic [2:0]  codes [5] = '{3'h1, 3'h4, 3'h5, 3'h6, 3'h7};
   int          errors = 0, n_tests = 0, i;

   always #2 hclk = ~hclk;

   gpcfg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .nvm_load(nvm_load),
      .nvm_pin6_default(nvm6), .nvm_pin7_default(nvm7), .pin6_in(p6_in), .pin6_out(p6_out),
      .pin6_oe(p6_oe), .pin6_pull_up(p6_pu), .pin6_pull_down(p6_pd), .pin7_in(p7_in),
      .pin7_out(p7_out), .pin7_oe(p7_oe), .pin7_pull_up(p7_pu), .pin7_pull_down(p7_pd),
      .sync_clock_source(sync_src), .power_good_source(pg_src), .mcu_error_input(err_o),
      .sleep_request_1(slp1), .sleep_request_2(slp2), .wake_input_1(wk1),
      .wake_input_2(wk2), .reference_voltage_output(ref_o), .voltage_monitor_input_1(vmon_o));
   gpcfg_pad_model u_pad6 (.hclk(hclk), .oe(p6_oe), .out(p6_out), .pull_up(p6_pu),
      .pull_down(p6_pd), .ext_en(e6_en), .ext_lvl(e6_lvl), .pin(p6_in));
   gpcfg_pad_model u_pad7 (.hclk(hclk), .oe(p7_oe), .out(p7_out), .pull_up(p7_pu),
      .pull_down(p7_pd), .ext_en(e7_en), .ext_lvl(e7_lvl), .pin(p7_in));

   // ****************
   // tasks
   // ****************
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // single transfer; address held until hready, data held until hready again
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task settle;
      repeat (2) @(posedge hclk);
   endtask

   function automatic logic routed(input logic [2:0] c);
      case (c)
         3'h1: routed = err_o;
         3'h4: routed = slp1;
         3'h5: routed = slp2;
         3'h6: routed = wk1;
         default: routed = wk2;
      endcase
   endfunction

   task summarize;
      if (errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ****************
   // tests
   // ****************
   initial begin
      #100000;
      errors++;
      summarize();
   end

   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      settle();
      bus(1'b0, PIN6_ADDR, 32'h0);
      chk(rd, {24'h0, CFG_RESET});
      bus(1'b0, PIN7_ADDR, 32'h0);
      chk(rd, {24'h0, CFG_RESET});
      chk({p6_pu, p6_pd, p6_oe, p7_pu, p7_pd, p7_oe}, 6'h12);
      bus(1'b0, 32'h100, 32'h0);
      chk(rd, 32'h0);
      nvm6 <= 8'h0C;
      nvm7 <= 8'h40;
      nvm_load <= 1'b1;
      @(posedge hclk);
      nvm_load <= 1'b0;
      settle();
      bus(1'b0, PIN6_ADDR, 32'h0);
      chk(rd, 32'h0C);
      bus(1'b0, PIN7_ADDR, 32'h0);
      chk(rd, 32'h40);
      chk({p6_pu, p6_pd, p7_pu, p7_pd, p7_oe, ref_o, vmon_o}, 7'h42);
      bus(1'b1, PIN7_ADDR, 32'h60);
      settle();
      chk({ref_o, vmon_o, p7_oe}, 3'h2);
      for (i = 0; i < 4; i++) begin
         bus(1'b1, PIN6_ADDR, i[1] ? 32'h03 : 32'h01);
         bus(1'b1, DATA_ADDR, {31'h0, i[0]});
         settle();
         chk({p6_oe, p6_out}, {!(i[1] && i[0]), i[0] && !i[1]});
      end
      for (i = 0; i < 4; i++) begin
         sync_src <= i[0];
         pg_src <= i[0];
         bus(1'b1, PIN6_ADDR, i[1] ? 32'h60 : 32'h40);
         settle();
         chk({p6_oe, p6_out}, {1'b1, i[0]});
      end
      bus(1'b1, PIN7_ADDR, 32'h00);
      e6_en <= 1'b1;
      for (i = 0; i < 5; i++) begin
         idl = (codes[i] < FUNC_WAKE1) ? ERR_IDLE : WAKE_IDLE;
         e6_lvl <= !idl;
         bus(1'b1, PIN6_ADDR, {24'h0, codes[i], 5'h00});
         repeat (6) @(posedge hclk);
         chk(routed(codes[i]), !idl);
         e6_lvl <= idl;
         repeat (5) @(posedge hclk);
         chk(routed(codes[i]), idl);
      end
      // pin6 released so pin7 owns the error route
      bus(1'b1, PIN6_ADDR, 32'h00);
      e6_en <= 1'b0;
      e7_en <= 1'b1;
      e7_lvl <= 1'b1;
      bus(1'b1, PIN7_ADDR, 32'h30);
      repeat (2100) @(posedge hclk);
      chk(err_o, 1'b1);
      e7_lvl <= 1'b0;
      repeat (1000) @(posedge hclk);
      e7_lvl <= 1'b1;
      @(posedge hclk);
      e7_lvl <= 1'b0;
      repeat (1500) @(posedge hclk);
      chk(err_o, 1'b1);
      repeat (600) @(posedge hclk);
      chk(err_o, 1'b0);
      bus(1'b0, DATA_ADDR, 32'h0);
      chk(rd[IN7_BIT], 1'b0);
      bus(1'b1, PIN6_ADDR, 32'h04);
      settle();
      chk({p6_pu, p6_pd}, 2'h0);
      bus(1'b1, PIN6_ADDR, 32'h0C);
      settle();
      chk({p6_pu, p6_pd}, 2'h2);
      // second pin as plain output: push-pull drives, open drain releases a high
      bus(1'b1, PIN7_ADDR, 32'h01);
      bus(1'b1, DATA_ADDR, 32'h02);
      settle();
      chk({p7_oe, p7_out}, 2'h3);
      bus(1'b1, PIN7_ADDR, 32'h03);
      settle();
      chk({p7_oe, p7_out}, 2'h0);
      summarize();
   end
endmodule // gpio_pin_function_config_tb_top
